/* usrc_top.sv */
// Reset, clock-stop, low-power and startup control for the USB module.
// Assumes all inputs except the data lines are synchronous to clock; tick48 pulses once per
// 48 MHz period and the data lines are raw pin levels.
`timescale 1ns/1ps
`default_nettype none
`include "usrc_map.svh"
module usrc_top #(
  parameter int unsigned SUSP_CYCLES = `USRC_SUSP_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic chip_standby_pin_n,
  input wire logic chip_reset_pin_n,
  input wire logic module_stop_wr,
  input wire logic module_stop_wdata,
  input wire logic reset_bits_wr,
  input wire logic interface_reset_wdata,
  input wire logic clock_pll_reset_wdata,
  input wire logic function_core_reset_wdata,
  input wire logic clock_ready_wr,
  input wire logic clock_ready_wdata,
  input wire logic [2:0] pll_freq_select,
  input wire logic sleep_exec,
  input wire logic standby_select_bit,
  input wire logic flag_clear_wr,
  input wire logic [2:0] flag_clear_mask,
  input wire logic tick48,
  input wire logic bus_data_plus,
  input wire logic bus_data_minus,
  input wire logic ep0_in_data_wr,
  input wire logic [7:0] ep0_in_data_port,
  input wire logic [6:0] endpoint_descriptor_addr,
  input wire logic token_valid,
  input wire logic [1:0] token_xfer_type,
  output logic pins_hiz,
  output logic pins_input_mode,
  output logic osc_enable,
  output logic usb_module_stop_bit,
  output logic usb_sysclk_enable,
  output logic interface_reset_bit,
  output logic clock_pll_reset_bit,
  output logic function_core_reset_bit,
  output logic usb_clock_ready_bit,
  output logic [5:0] pll_mult_x10,
  output logic clk24_out,
  output logic standby_active,
  output logic wake_request,
  output logic bus_reset_flag,
  output logic suspend_entry_flag,
  output logic suspend_exit_flag,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic endpoint_descriptor_loaded,
  output logic [7:0] endpoint_descriptor_data,
  output logic iso_rejected
);

  // ****************************************************************
  // State and leaf blocks
  // ****************************************************************
  usrc_pkg::usrc_state_s s_q;
  usrc_pkg::usrc_state_s s_d;
  logic [1:0] line_sync;
  logic init;
  logic mem_wr;
  logic line_change;
  logic ev_brst;
  logic ev_sent;
  logic ev_sexit;
  usrc_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din({bus_data_plus, bus_data_minus}),
    .dout(line_sync)
  );
  // Bytes past the 65th are dropped so a runaway loop cannot overwrite.
  assign mem_wr = ep0_in_data_wr && !s_q.core_rst && !s_q.ep_loaded;
  usrc_endpoint_descriptor_mem u_mem (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(mem_wr),
    .wr_addr(s_q.wptr),
    .wr_data(ep0_in_data_port),
    .rd_addr(endpoint_descriptor_addr),
    .rd_data(endpoint_descriptor_data)
  );
  assign init = !rst_n || !chip_standby_pin_n || !chip_reset_pin_n;
  assign line_change = (line_sync != s_q.line_prev);
  assign ev_brst = (s_q.bstate != usrc_pkg::BUS_RESET) &&
                   (line_sync == `USRC_LINE_SE0) &&
                   (s_q.se0_cnt == 8'(`USRC_BRST_CYCLES - 1));
  assign ev_sent = (s_q.bstate == usrc_pkg::BUS_ACTIVE) && !line_change &&
                   (s_q.idle_cnt == 19'(SUSP_CYCLES - 1));
  assign ev_sexit = (s_q.bstate == usrc_pkg::BUS_SUSPEND) && line_change;
  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.rx_valid = 1'b0;
    s_d.wake_req = 1'b0;
    // Software standby touches no USB state, only the wake path.
    s_d.standby = sleep_exec ? standby_select_bit : s_q.standby;
    if (s_q.standby && ev_sexit) begin
      s_d.wake_req = 1'b1;
      s_d.standby = 1'b0;
    end
    s_d.mod_stop = module_stop_wr ? module_stop_wdata : s_q.mod_stop;
    s_d.sysclk_en = !s_d.mod_stop;
    if (reset_bits_wr) begin
      s_d.iface_rst = interface_reset_wdata;
      s_d.pll_rst = clock_pll_reset_wdata;
      s_d.core_rst = function_core_reset_wdata;
    end
    if (clock_ready_wr) begin
      s_d.clk_ready = clock_ready_wdata;
    end
    unique case (pll_freq_select)
      `USRC_PLL_FREQ_SELECT_8: s_d.pll_mult = `USRC_MULT_X10_8;
      `USRC_PLL_FREQ_SELECT_12: s_d.pll_mult = `USRC_MULT_X10_12;
      `USRC_PLL_FREQ_SELECT_16: s_d.pll_mult = `USRC_MULT_X10_16;
      `USRC_PLL_FREQ_SELECT_20: s_d.pll_mult = `USRC_MULT_X10_20;
      `USRC_PLL_FREQ_SELECT_24: s_d.pll_mult = `USRC_MULT_X10_24;
      default: s_d.pll_mult = s_q.pll_mult;
    endcase
    s_d.clk24 = s_q.clk24 ^ tick48;
    // Bus condition tracking on the synchronised line.
    s_d.line_prev = line_sync;
    s_d.se0_cnt = (line_sync == `USRC_LINE_SE0) ?
                  ((s_q.se0_cnt == 8'hff) ? s_q.se0_cnt : s_q.se0_cnt + 8'h01)
                  : 8'h00;
    s_d.idle_cnt = line_change ? 19'h0 :
                   ((s_q.idle_cnt == 19'h7ffff) ? s_q.idle_cnt :
                    s_q.idle_cnt + 19'h1);
    unique case (s_q.bstate)
      usrc_pkg::BUS_ACTIVE: begin
        if (ev_brst) begin
          s_d.bstate = usrc_pkg::BUS_RESET;
        end else if (ev_sent) begin
          s_d.bstate = usrc_pkg::BUS_SUSPEND;
        end
      end
      usrc_pkg::BUS_SUSPEND: begin
        if (ev_brst) begin
          s_d.bstate = usrc_pkg::BUS_RESET;
        end else if (line_change) begin
          s_d.bstate = usrc_pkg::BUS_ACTIVE;
        end
      end
      usrc_pkg::BUS_RESET: begin
        if (line_sync != `USRC_LINE_SE0) begin
          s_d.bstate = usrc_pkg::BUS_ACTIVE;
        end
      end
      default: s_d.bstate = usrc_pkg::BUS_ACTIVE;
    endcase
    // A set in the same cycle as a clear wins.
    if (flag_clear_wr) begin
      s_d.brst_flag = s_q.brst_flag && !flag_clear_mask[0];
      s_d.sent_flag = s_q.sent_flag && !flag_clear_mask[1];
      s_d.sexit_flag = s_q.sexit_flag && !flag_clear_mask[2];
    end
    if (ev_brst) begin
      s_d.brst_flag = 1'b1;
    end
    if (ev_sent) begin
      s_d.sent_flag = 1'b1;
    end
    if (ev_sexit) begin
      s_d.sexit_flag = 1'b1;
    end
    // Phase is realigned on every edge, which covers the sync pattern
    // at the start of each packet; a stuck line just free-runs.
    if (tick48 && s_q.clk_ready) begin
      s_d.dline = line_sync;
      if (line_sync != s_q.dline) begin
        s_d.dph = 2'h0;
      end else begin
        s_d.dph = s_q.dph + 2'h1;
      end
      if (s_q.dph == `USRC_DPLL_SAMPLE) begin
        s_d.rx_bit = s_q.dline[1];
        s_d.rx_valid = 1'b1;
      end
    end
    if (s_q.pll_rst) begin
      s_d.dph = 2'h0;
      s_d.rx_valid = 1'b0;
    end
    if (mem_wr) begin
      s_d.wptr = s_q.wptr + 7'h01;
      s_d.ep_loaded = (s_q.wptr == `USRC_ENDPOINT_DESCRIPTOR_BYTES - 7'h01);
    end
    s_d.iso_reject = token_valid && (token_xfer_type == `USRC_XFER_ISO);
    if (s_q.core_rst) begin
      s_d.brst_flag = 1'b0;
      s_d.sent_flag = 1'b0;
      s_d.sexit_flag = 1'b0;
      s_d.wptr = 7'h00;
      s_d.ep_loaded = 1'b0;
      s_d.se0_cnt = 8'h00;
      s_d.bstate = usrc_pkg::BUS_ACTIVE;
      s_d.iso_reject = 1'b0;
    end
    s_d.pins_hiz = 1'b0;
    s_d.pins_input = 1'b0;
    s_d.osc_en = 1'b1;
    if (init) begin
      s_d = '0;
      s_d.bstate = usrc_pkg::BUS_ACTIVE;
      s_d.pll_mult = `USRC_MULT_X10_RST;
      s_d.mod_stop = 1'b1;
      s_d.iface_rst = 1'b1;
      s_d.pll_rst = 1'b1;
      s_d.core_rst = 1'b1;
      s_d.pins_hiz = !chip_standby_pin_n;
      s_d.osc_en = chip_standby_pin_n;
      s_d.pins_input = chip_standby_pin_n;
    end
  end
  always_ff @(posedge clock) begin
    s_q <= s_d;
  end
  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pins_hiz = s_q.pins_hiz;
  assign pins_input_mode = s_q.pins_input;
  assign osc_enable = s_q.osc_en;
  assign usb_module_stop_bit = s_q.mod_stop;
  assign usb_sysclk_enable = s_q.sysclk_en;
  assign interface_reset_bit = s_q.iface_rst;
  assign clock_pll_reset_bit = s_q.pll_rst;
  assign function_core_reset_bit = s_q.core_rst;
  assign usb_clock_ready_bit = s_q.clk_ready;
  assign pll_mult_x10 = s_q.pll_mult;
  assign clk24_out = s_q.clk24;
  assign standby_active = s_q.standby;
  assign wake_request = s_q.wake_req;
  assign bus_reset_flag = s_q.brst_flag;
  assign suspend_entry_flag = s_q.sent_flag;
  assign suspend_exit_flag = s_q.sexit_flag;
  assign rx_bit = s_q.rx_bit;
  assign rx_bit_valid = s_q.rx_valid;
  assign endpoint_descriptor_loaded = s_q.ep_loaded;
  assign iso_rejected = s_q.iso_reject;
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_core_release;
    !init && reset_bits_wr && !function_core_reset_wdata;
  endsequence
  sequence s_core_held;
    function_core_reset_bit && !reset_bits_wr && !init;
  endsequence
  property p_standby_hiz;
    !chip_standby_pin_n |=> pins_hiz && !osc_enable && !pins_input_mode;
  endproperty
  a_standby_hiz: assert property (p_standby_hiz) else $error("standby");
  property p_reset_input;
    chip_standby_pin_n && !chip_reset_pin_n |=>
      pins_input_mode && osc_enable && !pins_hiz;
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("reset");
  property p_modstop_gate;
    usb_module_stop_bit |-> !usb_sysclk_enable;
  endproperty
  a_modstop_gate: assert property (p_modstop_gate) else $error("gate");
  property p_init_stop;
    init ##1 !init |-> usb_module_stop_bit && function_core_reset_bit;
  endproperty
  a_init_stop: assert property (p_init_stop) else $error("init");
  property p_release;
    s_core_release |=> !function_core_reset_bit;
  endproperty
  a_release: assert property (p_release) else $error("release");
  property p_hold;
    s_core_held |=> function_core_reset_bit;
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_core_clear;
    function_core_reset_bit && !init |=> !bus_reset_flag &&
      !endpoint_descriptor_loaded && !suspend_entry_flag;
  endproperty
  a_core_clear: assert property (p_core_clear) else $error("clear");
  property p_brst;
    ev_brst && !init && !function_core_reset_bit && !reset_bits_wr |=>
      bus_reset_flag && $stable(interface_reset_bit);
  endproperty
  a_brst: assert property (p_brst) else $error("bus reset");
  property p_susp;
    ev_sent && !init && !function_core_reset_bit |=> suspend_entry_flag;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend");
  property p_wake;
    standby_active && ev_sexit && !init |=> wake_request ##1 !wake_request;
  endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_iso;
    token_valid && token_xfer_type == `USRC_XFER_ISO && !init &&
      !function_core_reset_bit |=> iso_rejected;
  endproperty
  a_iso: assert property (p_iso) else $error("iso");
  property p_dpll;
    rx_bit_valid |-> $past(tick48) && !$past(clock_pll_reset_bit);
  endproperty
  a_dpll: assert property (p_dpll) else $error("dpll");

endmodule : usrc_top
`default_nettype wire

/* usrc_map.svh */
// Offsets, reset values and timing counts for the USB reset/startup block.
// Assumes a 100 MHz system clock; included by its bare name.
`ifndef USRC_MAP_SVH
`define USRC_MAP_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define USRC_CLK_PERIOD_NS 10
`define USRC_SUSP_TIME_US 3000
`define USRC_SUSP_CYCLES (`USRC_SUSP_TIME_US * 1000 / `USRC_CLK_PERIOD_NS)
`define USRC_BRST_TIME_NS 2500
`define USRC_BRST_CYCLES \
  ((`USRC_BRST_TIME_NS + `USRC_CLK_PERIOD_NS - 1) / `USRC_CLK_PERIOD_NS)
`define USRC_DPLL_PHASES 4
`define USRC_DPLL_SAMPLE 2'h2

// ****************************************************************
// Endpoint descriptor and line states
// ****************************************************************
`define USRC_ENDPOINT_DESCRIPTOR_BYTES 7'h41
`define USRC_LINE_SE0 2'h0
`define USRC_XFER_ISO 2'h1
`define USRC_PLL_FREQ_SELECT_8 3'h0
`define USRC_PLL_FREQ_SELECT_12 3'h1
`define USRC_PLL_FREQ_SELECT_16 3'h2
`define USRC_PLL_FREQ_SELECT_20 3'h3
`define USRC_PLL_FREQ_SELECT_24 3'h4
`define USRC_MULT_X10_8 6'h3c
`define USRC_MULT_X10_12 6'h28
`define USRC_MULT_X10_16 6'h1e
`define USRC_MULT_X10_20 6'h18
`define USRC_MULT_X10_24 6'h14
`define USRC_MULT_X10_RST 6'h14

`endif

/* usrc_pkg.sv */
// Types shared by the USB reset/startup block.
// Assumes nothing of its surroundings.
`default_nettype none
package usrc_pkg;

  // ****************************************************************
  // Bus condition states
  // ****************************************************************
  typedef enum logic [2:0] {
    BUS_ACTIVE  = 3'h1,
    BUS_SUSPEND = 3'h2,
    BUS_RESET   = 3'h4
  } usrc_bus_e;

  typedef struct packed {
    logic pins_hiz;
    logic pins_input;
    logic osc_en;
    logic mod_stop;
    logic sysclk_en;
    logic iface_rst;
    logic pll_rst;
    logic core_rst;
    logic clk_ready;
    logic [5:0] pll_mult;
    logic clk24;
    logic standby;
    logic wake_req;
    usrc_bus_e bstate;
    logic [18:0] idle_cnt;
    logic [7:0] se0_cnt;
    logic [1:0] line_prev;
    logic brst_flag;
    logic sent_flag;
    logic sexit_flag;
    logic [1:0] dph;
    logic [1:0] dline;
    logic rx_bit;
    logic rx_valid;
    logic [6:0] wptr;
    logic ep_loaded;
    logic iso_reject;
  } usrc_state_s;

endpackage : usrc_pkg
`default_nettype wire

/* usrc_sync.sv */
// Two-flop synchroniser for the USB data line levels.
// Assumes the inputs are levels that may change at any time.
`timescale 1ns/1ps
`default_nettype none
module usrc_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] din,
  output logic [1:0] dout
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } usrc_sync_s;

  usrc_sync_s s_q;
  usrc_sync_s s_d;

  // The first stage feeds only the second stage.
  always_comb begin
    s_d.meta = din;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stable;

endmodule : usrc_sync
`default_nettype wire

/* usrc_endpoint_descriptor_mem.sv */
// Storage for the 65-byte endpoint descriptor, with registered read data.
// Assumes writes arrive in ascending address order from the controller.
`timescale 1ns/1ps
`default_nettype none
`include "usrc_map.svh"
module usrc_endpoint_descriptor_mem (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data
);

  typedef struct packed {
    logic [64:0][7:0] mem;
    logic [7:0] rdata;
  } usrc_mem_s;

  usrc_mem_s s_q;
  usrc_mem_s s_d;

  always_comb begin
    s_d = s_q;
    if (wr_en && (wr_addr < `USRC_ENDPOINT_DESCRIPTOR_BYTES)) begin
      s_d.mem[wr_addr] = wr_data;
    end
    // Out-of-range reads return zero rather than aliasing.
    s_d.rdata = (rd_addr < `USRC_ENDPOINT_DESCRIPTOR_BYTES) ? s_q.mem[rd_addr] : 8'h00;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rdata;

endmodule : usrc_endpoint_descriptor_mem
`default_nettype wire

/* usrc_host_model.sv */
// Host side of the full-speed bus: data line levels and the 48 MHz tick.
// Assumes a 100 MHz clock; line_cmd is changed by the bench after edges.
`timescale 1ns/1ps
`default_nettype none
module usrc_host_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] line_cmd,
  output logic tick48,
  output logic bus_dp,
  output logic bus_dm
);
  // ****************************************
  // Tick and line drivers
  // ****************************************
  int acc = 0;
  int bit_cnt = 0;
  logic tog_q = 1'b0;
  logic tick_q = 1'b0;

  // The 48 MHz clock never stops, even in reset or module stop.
  always_ff @(posedge clock) begin
    acc <= (acc + 48) % 100;
    tick_q <= (acc + 48) >= 100;
    bit_cnt <= (bit_cnt + 1) % 8;
    if (bit_cnt == 7) begin
      tog_q <= !tog_q;
    end
  end

  // Command 0 idles at J through the plus-line pull-up, 1 holds SE0 as a
  // bus reset, 2 sends K/J edges at about 12 Mbps.
  always_comb begin
    tick48 = tick_q;
    bus_dp = (line_cmd == 2'h1) ? 1'b0 : (line_cmd == 2'h2) ? tog_q : 1'b1;
    bus_dm = (line_cmd == 2'h2) ? !tog_q : 1'b0;
  end
endmodule : usrc_host_model
`default_nettype wire

/* usrc_top_bench.sv */
// Self-checking bench for the USB reset/startup block.
// Assumes the design files and usrc_host_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module usrc_top_bench;
  // Idle time kept above the 250-cycle bus reset so SE0 is not taken
  // for an idle bus; PLL settling is shortened from 3 ms to keep runs short.
  localparam int SUSP = 300;
  localparam int PLL_WAIT = 30;
  localparam logic [39:0] EPD [13] = '{40'h0000110000, 40'h1438100001,
    40'h2438100002, 40'h1478100001, 40'h2470100002, 40'h14b8200001,
    40'h3520100003, 40'h4520100004, 40'h5520100005, 40'h6520100006,
    40'h3620100003, 40'h4620100004, 40'h5620100005};
  int mt[5] = '{60, 40, 30, 24, 20};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic chip_standby_pin_n = 1'b1, chip_reset_pin_n = 1'b1;
  logic module_stop_wr = 1'b0, module_stop_wdata = 1'b0;
  logic reset_bits_wr = 1'b0, interface_reset_wdata = 1'b1;
  logic clock_pll_reset_wdata = 1'b1, function_core_reset_wdata = 1'b1;
  logic clock_ready_wr = 1'b0, clock_ready_wdata = 1'b0;
  logic [2:0] pll_freq_select = 3'h7;
  logic sleep_exec = 1'b0, standby_select_bit = 1'b0;
  logic flag_clear_wr = 1'b0;
  logic [2:0] flag_clear_mask = 3'h0;
  logic ep0_in_data_wr = 1'b0, token_valid = 1'b0;
  logic [7:0] ep0_in_data_port = 8'h00;
  logic [6:0] endpoint_descriptor_addr = 7'h00;
  logic [1:0] token_xfer_type = 2'h0, line_cmd = 2'h0;
  logic tick48, bus_data_plus, bus_data_minus;
  logic pins_hiz, pins_input_mode, osc_enable, usb_module_stop_bit;
  logic usb_sysclk_enable, interface_reset_bit, clock_pll_reset_bit;
  logic function_core_reset_bit, usb_clock_ready_bit, clk24_out;
  logic standby_active, wake_request, bus_reset_flag, suspend_entry_flag;
  logic suspend_exit_flag, rx_bit, rx_bit_valid, iso_rejected;
  logic endpoint_descriptor_loaded;
  logic [5:0] pll_mult_x10;
  logic [7:0] endpoint_descriptor_data;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int m_stop, m_rb, m_rdy, m_mult;

  usrc_top #(.SUSP_CYCLES(SUSP)) u_usrc_top (.clock, .rst_n,
    .chip_standby_pin_n, .chip_reset_pin_n, .module_stop_wr,
    .module_stop_wdata, .reset_bits_wr, .interface_reset_wdata,
    .clock_pll_reset_wdata, .function_core_reset_wdata, .clock_ready_wr,
    .clock_ready_wdata, .pll_freq_select, .sleep_exec, .standby_select_bit,
    .flag_clear_wr, .flag_clear_mask, .tick48, .bus_data_plus,
    .bus_data_minus, .ep0_in_data_wr, .ep0_in_data_port,
    .endpoint_descriptor_addr, .token_valid, .token_xfer_type, .pins_hiz,
    .pins_input_mode, .osc_enable, .usb_module_stop_bit, .usb_sysclk_enable,
    .interface_reset_bit, .clock_pll_reset_bit, .function_core_reset_bit,
    .usb_clock_ready_bit, .pll_mult_x10, .clk24_out, .standby_active,
    .wake_request, .bus_reset_flag, .suspend_entry_flag, .suspend_exit_flag,
    .rx_bit, .rx_bit_valid, .endpoint_descriptor_loaded,
    .endpoint_descriptor_data, .iso_rejected);

  usrc_host_model u_usrc_host_model (.clock, .rst_n, .line_cmd, .tick48,
    .bus_dp(bus_data_plus), .bus_dm(bus_data_minus));

  // ****************************************
  // Clock, watchdog and shared tasks
  // ****************************************
  initial begin
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  task automatic check_ctrl();
    check(usb_module_stop_bit, m_stop, "module stop");
    check(usb_sysclk_enable, !m_stop, "system clock gate");
    check({interface_reset_bit, clock_pll_reset_bit, function_core_reset_bit},
          m_rb, "reset bits");
    check(usb_clock_ready_bit, m_rdy, "clock ready");
    check(pll_mult_x10, m_mult, "pll multiplier");
  endtask : check_ctrl

  task automatic model_reset();
    m_stop = 1;
    m_rb = 7;
    m_rdy = 0;
    m_mult = 20;
  endtask : model_reset

  task automatic wr_ctrl(input int stop, input int rb, input int rdy);
    module_stop_wr = 1'b1;
    module_stop_wdata = stop[0];
    reset_bits_wr = 1'b1;
    {interface_reset_wdata, clock_pll_reset_wdata,
     function_core_reset_wdata} = rb[2:0];
    clock_ready_wr = 1'b1;
    clock_ready_wdata = rdy[0];
    step(1);
    module_stop_wr = 1'b0;
    reset_bits_wr = 1'b0;
    clock_ready_wr = 1'b0;
    // One idle edge keeps back-to-back writes from re-raising a strobe.
    step(1);
    m_stop = stop;
    m_rb = rb;
    m_rdy = rdy;
    check_ctrl();
  endtask : wr_ctrl

  task automatic clear_flags(input logic [2:0] mask);
    flag_clear_wr = 1'b1;
    flag_clear_mask = mask;
    step(1);
    flag_clear_wr = 1'b0;
  endtask : clear_flags

  task automatic count_valid(input int n, output int cnt);
    int k;
    logic last;
    cnt = 0;
    k = 0;
    last = 1'b0;
    // Each toggled bit lasts three or four ticks, so it is sampled once and
    // the samples alternate; the first two may still be the idle level.
    repeat (n) begin
      step(1);
      if (rx_bit_valid === 1'b1) begin
        if (k > 1) begin
          check(rx_bit, !last, "sampled bit");
        end
        k++;
        last = rx_bit;
      end
      cnt += rx_bit_valid;
    end
  endtask : count_valid

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic [31:0] seed;
    logic [7:0] q[$];
    int n, m, p;
    seed = 32'hfcc4;
    model_reset();
    step(2);
    check({pins_hiz, osc_enable, pins_input_mode}, 3'b011, "in reset");
    step(2);
    rst_n = 1'b1;
    step(1);
    check_ctrl();
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr_ctrl(seed[0], seed[3:1], seed[4]);
    end
    for (int c = 0; c < 8; c++) begin
      pll_freq_select = c[2:0];
      step(2);
      if (c < 5) begin
        m_mult = mt[c];
      end
      check_ctrl();
    end
    n = 0;
    m = 0;
    p = clk24_out;
    repeat (100) begin
      step(1);
      n += tick48;
      m += (clk24_out !== p[0]);
      p = clk24_out;
    end
    check((n - m) * (n - m) <= 1 && n > 40, 1, "24 MHz toggles");
    done("control");
    wr_ctrl(0, 0, 1);
    chip_standby_pin_n = 1'b0;
    step(2);
    check({pins_hiz, osc_enable, pins_input_mode}, 3'b100, "standby");
    chip_standby_pin_n = 1'b1;
    step(1);
    model_reset();
    check_ctrl();
    check(pins_hiz, 0, "pins after standby");
    wr_ctrl(0, 0, 1);
    chip_reset_pin_n = 1'b0;
    step(2);
    check({pins_hiz, osc_enable, pins_input_mode}, 3'b011, "chip reset");
    chip_reset_pin_n = 1'b1;
    step(1);
    model_reset();
    check_ctrl();
    done("pins");
    // Startup order: all resets held while the PLL settles.
    wr_ctrl(0, 7, 0);
    step(PLL_WAIT);
    wr_ctrl(0, 7, 1);
    wr_ctrl(0, 3, 1);
    wr_ctrl(0, 1, 1);
    step(21);
    wr_ctrl(0, 0, 1);
    for (int r = 0; r < 13; r++) begin
      for (int j = 0; j < 5; j++) begin
        q.push_back(EPD[r][39 - 8 * j -: 8]);
      end
    end
    ep0_in_data_wr = 1'b1;
    for (int i = 0; i < 66; i++) begin
      ep0_in_data_port = (i < 65) ? q[i] : 8'hee;
      step(1);
      check(endpoint_descriptor_loaded, i >= 64, "loaded");
    end
    ep0_in_data_wr = 1'b0;
    for (int i = 0; i < 66; i++) begin
      endpoint_descriptor_addr = i[6:0];
      step(1);
      check(endpoint_descriptor_data, (i < 65) ? q[i] : 8'h00, "byte");
    end
    token_valid = 1'b1;
    for (int t = 0; t < 4; t++) begin
      token_xfer_type = t[1:0];
      step(1);
      check(iso_rejected, t == 1, "isochronous token");
    end
    token_valid = 1'b0;
    done("descriptor");
    line_cmd = 2'h2;
    count_valid(100, n);
    check(n > 5, 1, "bus sampling");
    wr_ctrl(0, 2, 1);
    count_valid(100, n);
    check(n, 0, "sampling held");
    wr_ctrl(0, 0, 1);
    line_cmd = 2'h1;
    step(200);
    check(bus_reset_flag, 0, "early bus reset");
    step(60);
    check(bus_reset_flag, 1, "bus reset");
    check_ctrl();
    line_cmd = 2'h0;
    clear_flags(3'h1);
    check(bus_reset_flag, 0, "bus reset cleared");
    wr_ctrl(0, 1, 1);
    step(1);
    check({bus_reset_flag, suspend_entry_flag, suspend_exit_flag,
           endpoint_descriptor_loaded}, 0, "core reset");
    wr_ctrl(0, 0, 1);
    done("bus reset");
    step(SUSP + 20);
    check(suspend_entry_flag, 1, "suspend entry");
    sleep_exec = 1'b1;
    step(1);
    check(standby_active, 0, "sleep without standby");
    standby_select_bit = 1'b1;
    step(1);
    sleep_exec = 1'b0;
    check(standby_active, 1, "standby entered");
    check_ctrl();
    wr_ctrl(0, 0, 0);
    clear_flags(3'h2);
    check({suspend_entry_flag, suspend_exit_flag}, 0, "suspend cleared");
    line_cmd = 2'h2;
    n = 0;
    repeat (20) begin
      step(1);
      n += wake_request;
    end
    check(n, 1, "one wake pulse");
    check({standby_active, suspend_exit_flag}, 2'b01, "woken");
    clear_flags(3'h4);
    check(suspend_exit_flag, 0, "exit cleared");
    // Standby regardless of the host: hold all resets, drop the pull-up.
    wr_ctrl(0, 7, 0);
    line_cmd = 2'h1;
    sleep_exec = 1'b1;
    step(1);
    sleep_exec = 1'b0;
    step(2);
    check(standby_active, 1, "standby with module held");
    check({bus_reset_flag, suspend_entry_flag, suspend_exit_flag}, 0,
          "flags held in core reset");
    check_ctrl();
    done("suspend");
    report_and_stop();
  end
endmodule : usrc_top_bench
`default_nettype wire
